/* sop_and_or_plane.sv */
`timescale 1ns/100ps
module sop_and_or_plane
    import sop_pkg::*;
(
    // Array side
    sop_array_if.plane arr
);

    logic [SOP_N_LINE-1:0] lit;
    logic [SOP_N_TERM-1:0] term;

    // ********************************************************
    // True and complement lines
    // ********************************************************
    // complementary input lines
    for (genvar i = 0; i < SOP_N_IN; i++) begin : g_lit
        assign lit[2*i] = arr.lines[i];
        assign lit[2*i+1] = ~arr.lines[i];
    end

    // ********************************************************
    // Product terms
    // ********************************************************
    // A cleared cell bit masks its line out, so an empty term is true
    for (genvar t = 0; t < SOP_N_TERM; t++) begin : g_term
        assign term[t] = &(lit | ~arr.cells[t]);
    end

    // ********************************************************
    // OR groups
    // ********************************************************
    for (genvar k = 0; k < SOP_N_CELL; k++) begin : g_grp
        assign arr.sum_all[k] = |term[k*SOP_TERMS_PER_CELL +: SOP_TERMS_PER_CELL];
        assign arr.sum_rest[k] = |term[k*SOP_TERMS_PER_CELL+1 +: SOP_TERMS_PER_CELL-1];
        assign arr.term_first[k] = term[k*SOP_TERMS_PER_CELL];
    end

endmodule : sop_and_or_plane

/* sop_array_if.sv */
`timescale 1ns/100ps
interface sop_array_if;
    logic [15:0] lines;
    logic [63:0][31:0] cells;
    logic [7:0] sum_all;
    logic [7:0] sum_rest;
    logic [7:0] term_first;

    modport plane (
        input lines,
        input cells,
        output sum_all,
        output sum_rest,
        output term_first
    );

    modport user (
        output lines,
        output cells,
        input sum_all,
        input sum_rest,
        input term_first
    );
endinterface : sop_array_if

/* sop_board_model.sv */
`timescale 1ns/100ps
module sop_board_model (
    // Clock
    input wire logic pclk,
    // Board drive request
    input wire logic [7:0] drv_val,
    input wire logic [7:0] drv_en,
    // Device macrocell pins
    input wire logic [7:0] cell_pin_out,
    input wire logic [7:0] cell_pin_oe,
    output logic [7:0] cell_pin_in
);
    logic [7:0] last_r = 8'h00;

    // Undriven wire drifts to the inverse of the last level driven onto it
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            if (cell_pin_oe[k]) begin
                cell_pin_in[k] = cell_pin_out[k];
            end else if (drv_en[k]) begin
                cell_pin_in[k] = drv_val[k];
            end else begin
                cell_pin_in[k] = ~last_r[k];
            end
        end
    end

    always_ff @(posedge pclk) begin
        for (int k = 0; k < 8; k++) begin
            if (cell_pin_oe[k] || drv_en[k]) begin
                last_r[k] <= cell_pin_in[k];
            end
        end
    end
endmodule : sop_board_model

/* sop_logic_array.sv */
`timescale 1ns/100ps
module sop_logic_array
    import sop_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Dedicated pins
    input wire logic clk_or_in_pin,
    input wire logic gate_n_or_in_pin,
    input wire logic [SOP_N_DED-1:0] ded_in,
    // Macrocell pins
    input wire logic [SOP_N_CELL-1:0] cell_pin_in,
    output logic [SOP_N_CELL-1:0] cell_pin_out,
    output logic [SOP_N_CELL-1:0] cell_pin_oe
);

    // ********************************************************
    // Declarations
    // ********************************************************
    sop_array_if arr ();

    logic [SOP_N_PIN_IN-1:0] pin_raw;
    logic [SOP_N_PIN_IN-1:0] sync1_r;
    logic [SOP_N_PIN_IN-1:0] sync2_r;
    logic clk_s;
    logic gate_n_s;
    logic [SOP_N_DED-1:0] ded_s;
    logic [SOP_N_CELL-1:0] cell_in_s;

    logic [63:0][31:0] cell_r;
    sop_mode_t mode_r;
    logic [7:0] in_sel_r;
    logic [7:0] io_sel_r;
    logic [7:0] pol_r;
    logic [SOP_N_CELL-1:0] q_r;
    logic [SOP_N_CELL-1:0] q_nxt;
    logic clk_prev_r;
    logic clk_armed_r;
    logic clk_rise;

    logic [SOP_N_CELL-1:0] is_reg;
    logic [SOP_N_CELL-1:0] is_in;
    logic [SOP_N_CELL-1:0] use_oe_term;
    logic [SOP_N_CELL-1:0] func;
    logic [SOP_N_CELL-1:0] func_pol;
    logic [SOP_N_CELL-1:0] feed;
    logic [SOP_N_CELL-1:0] out_nxt;
    logic [SOP_N_CELL-1:0] oe_nxt;

    logic setup_ph;
    logic wr_acc;
    logic [ADDR_W-1:0] word_addr;
    logic [31:0] rd_nxt;
    logic rd_err;
    logic [31:0] stat_word;
    logic ans_r;

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    assign pin_raw = {cell_pin_in, ded_in, gate_n_or_in_pin, clk_or_in_pin};

    // Pins are sampled on enabled edges only, so a pulse shorter than one
    // enabled cycle may be lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else if (ce) begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    assign clk_s = sync2_r[0];
    assign gate_n_s = sync2_r[1];
    assign ded_s = sync2_r[2 +: SOP_N_DED];
    assign cell_in_s = sync2_r[2+SOP_N_DED +: SOP_N_CELL];

    // ********************************************************
    // Clock pin edge detect
    // ********************************************************
    // Armed after one sample past reset; the synchronisers reset low, so a pin
    // already high at release still shows as one rising edge two samples later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_prev_r <= 1'b0;
            clk_armed_r <= 1'b0;
        end else if (ce) begin
            clk_prev_r <= clk_s;
            clk_armed_r <= 1'b1;
        end
    end

    assign clk_rise = clk_armed_r & clk_s & ~clk_prev_r;

    // ********************************************************
    // Macrocell configuration
    // ********************************************************
    always_comb begin
        for (int k = 0; k < SOP_N_CELL; k++) begin
            is_reg[k] = (mode_r == SOP_REGISTERED_EMULATION_MODE) && !io_sel_r[k];
            is_in[k] = (mode_r == SOP_SIMPLE_COMBINATORIAL_MODE) && in_sel_r[k]
                && (k != SOP_MID_LO) && (k != SOP_MID_HI);
            use_oe_term[k] = ((mode_r == SOP_REGISTERED_EMULATION_MODE) && io_sel_r[k])
                || (mode_r == SOP_MEDIUM_COMBINATORIAL_MODE);
            func[k] = use_oe_term[k] ? arr.sum_rest[k] : arr.sum_all[k];
            func_pol[k] = pol_r[k] ? func[k] : ~func[k];
        end
    end

    // ********************************************************
    // Array input lines
    // ********************************************************
    always_comb begin
        for (int k = 0; k < SOP_N_CELL; k++) begin
            feed[k] = is_reg[k] ? q_r[k] : cell_in_s[k];
        end
        // Cells with no pin feedback of their own in this mode lend their
        // lines to the two spare pins
        // spare pins as inputs
        if (mode_r == SOP_SIMPLE_COMBINATORIAL_MODE) begin
            feed[SOP_MID_LO] = clk_s;
            feed[SOP_MID_HI] = gate_n_s;
        end else if (mode_r == SOP_MEDIUM_COMBINATORIAL_MODE) begin
            feed[SOP_OUTER_LO] = clk_s;
            feed[SOP_OUTER_HI] = gate_n_s;
        end
    end

    assign arr.lines = {feed, ded_s};
    assign arr.cells = cell_r;

    sop_and_or_plane i_sop_and_or_plane (
        .arr (arr.plane)
    );

    // ********************************************************
    // Macrocell flip-flops
    // ********************************************************
    always_comb begin
        for (int k = 0; k < SOP_N_CELL; k++) begin
            q_nxt[k] = pol_r[k] ? ~func[k] : func[k];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= SOP_Q_RST;
        end else if (ce && clk_rise && mode_r == SOP_REGISTERED_EMULATION_MODE) begin
            for (int k = 0; k < SOP_N_CELL; k++) begin
                if (is_reg[k]) begin
                    q_r[k] <= q_nxt[k];
                end
            end
        end
    end

    // ********************************************************
    // Pin drivers
    // ********************************************************
    // The pin shows the inverse of the stored bit, so a cleared flop
    // drives high whichever polarity was chosen
    always_comb begin
        for (int k = 0; k < SOP_N_CELL; k++) begin
            if (is_reg[k]) begin
                out_nxt[k] = ~q_r[k];
                oe_nxt[k] = ~gate_n_s;
            end else if (is_in[k]) begin
                out_nxt[k] = 1'b0;
                oe_nxt[k] = 1'b0;
            end else begin
                out_nxt[k] = func_pol[k];
                oe_nxt[k] = use_oe_term[k] ? arr.term_first[k] : 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_pin_out <= '0;
            cell_pin_oe <= '0;
        end else if (ce) begin
            cell_pin_out <= out_nxt;
            cell_pin_oe <= oe_nxt;
        end
    end

    // ********************************************************
    // APB decode
    // ********************************************************
    // Zero wait states once the answer is latched; a low enable stalls the
    // bus with the rest, and a setup edge lost to it costs one wait state
    assign pready = ce && ans_r;
    assign setup_ph = psel && !ans_r;
    assign wr_acc = psel && penable && pwrite && pready;
    assign word_addr = {paddr[ADDR_W-1:2], 2'b00};

    always_comb begin
        stat_word = '0;
        stat_word[SOP_STAT_Q_LSB +: SOP_N_CELL] = q_r;
        stat_word[SOP_STAT_OUT_LSB +: SOP_N_CELL] = cell_pin_out;
        stat_word[SOP_STAT_OE_LSB +: SOP_N_CELL] = cell_pin_oe;
        stat_word[SOP_STAT_CLK_BIT] = clk_s;
        stat_word[SOP_STAT_GATE_BIT] = gate_n_s;
    end

    always_comb begin
        rd_nxt = '0;
        rd_err = 1'b0;
        if (word_addr <= SOP_CELL_LAST) begin
            rd_nxt = cell_r[word_addr[7:2]];
        end else if (word_addr == SOP_MODE_OFS) begin
            rd_nxt = {30'h0000_0000, mode_r};
        end else if (word_addr == SOP_MCFG_OFS) begin
            rd_nxt = {8'h00, pol_r, io_sel_r, in_sel_r};
        end else if (word_addr == SOP_STAT_OFS) begin
            rd_nxt = stat_word;
        end else begin
            rd_err = 1'b1;
        end
    end

    // Answer is prepared in the setup cycle and held through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (ce && setup_ph) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr <= rd_err;
        end
    end

    // Set when the answer is latched, cleared as the access completes;
    // without it a stalled setup edge would hand back stale read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ans_r <= 1'b0;
        end else if (ce && psel && !ans_r) begin
            ans_r <= 1'b1;
        end else if (ce && psel && penable) begin
            ans_r <= 1'b0;
        end
    end

    // ********************************************************
    // Connection cells
    // ********************************************************
    // Writes land only on the completing access edge, never twice per access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_r <= {SOP_N_TERM{SOP_CELL_RST}};
        end else if (wr_acc && word_addr <= SOP_CELL_LAST) begin
            cell_r[word_addr[7:2]] <= pwdata;
        end
    end

    // ********************************************************
    // Architecture registers
    // ********************************************************
    // Leaving registered mode keeps the flop contents for a later return
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= SOP_MODE_RST;
        end else if (wr_acc && word_addr == SOP_MODE_OFS) begin
            case (pwdata[1:0])
                2'b00: mode_r <= SOP_SIMPLE_COMBINATORIAL_MODE;
                2'b01: mode_r <= SOP_REGISTERED_EMULATION_MODE;
                2'b10: mode_r <= SOP_MEDIUM_COMBINATORIAL_MODE;
                default: mode_r <= mode_r;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_sel_r <= SOP_IN_SEL_RST;
            io_sel_r <= SOP_IO_SEL_RST;
            pol_r <= SOP_POL_RST;
        end else if (wr_acc && word_addr == SOP_MCFG_OFS) begin
            in_sel_r <= pwdata[SOP_MCFG_IN_LSB +: 8];
            io_sel_r <= pwdata[SOP_MCFG_IO_LSB +: 8];
            pol_r <= pwdata[SOP_MCFG_POL_LSB +: 8];
        end
    end

endmodule : sop_logic_array

/* sop_logic_array_properties.sv */
`timescale 1ns/100ps
module sop_logic_array_properties
    import sop_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic clk_or_in_pin,
    input wire logic gate_n_or_in_pin,
    input wire logic [SOP_N_DED-1:0] ded_in,
    input wire logic [SOP_N_CELL-1:0] cell_pin_in,
    input wire logic [SOP_N_CELL-1:0] cell_pin_out,
    input wire logic [SOP_N_CELL-1:0] cell_pin_oe
);
    // ************
    // Configuration mirror
    // ************
    logic [1:0] mode_r;
    logic [23:0] mcfg_r;
    logic [3:0] age_r;
    logic seen_r;
    logic wr_hit;
    logic reg_mode;

    assign wr_hit = psel && penable && pwrite && pready;
    assign reg_mode = (mode_r == 2'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= 2'h0;
            mcfg_r <= 24'h0;
        end else if (wr_hit && paddr == ADDR_W'(SOP_MODE_OFS) && pwdata[1:0] != 2'h3) begin
            mode_r <= pwdata[1:0];
        end else if (wr_hit && paddr == ADDR_W'(SOP_MCFG_OFS)) begin
            mcfg_r <= pwdata[23:0];
        end
    end

    // Settling time after any write, so the sync pipeline is flushed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_r <= 4'h0;
        end else if (wr_hit || !ce) begin
            age_r <= 4'h0;
        end else if (age_r != 4'hF) begin
            age_r <= age_r + 4'h1;
        end
    end

    // Any high level on the clock pin in registered mode may have clocked the flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_r <= 1'b0;
        end else if (clk_or_in_pin && reg_mode) begin
            seen_r <= 1'b1;
        end
    end

    // ************
    // Properties
    // ************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_reset_clears_pins: assert property (
        $rose(presetn) |-> cell_pin_out == 8'h00 && cell_pin_oe == 8'h00)
        else $error("pins not cleared by reset");
    a_simple_outputs_on: assert property (
        mode_r == 2'h0 && age_r > 4'h3 |-> (cell_pin_oe | (mcfg_r[7:0] & 8'hE7)) == 8'hFF)
        else $error("simple mode output not driving");
    a_input_cell_quiet: assert property (
        mode_r == 2'h0 && age_r > 4'h3 |-> (cell_pin_oe & mcfg_r[7:0] & 8'hE7) == 8'h00)
        else $error("input macrocell is driving");
    a_gate_high_off: assert property (
        (reg_mode && age_r > 4'h3 && gate_n_or_in_pin) [*4]
        |-> (cell_pin_oe & ~mcfg_r[15:8]) == 8'h00)
        else $error("registered output driving with gate high");
    a_gate_low_on: assert property (
        (reg_mode && age_r > 4'h3 && !gate_n_or_in_pin) [*4]
        |-> (cell_pin_oe | mcfg_r[15:8]) == 8'hFF)
        else $error("registered output idle with gate low");
    a_reg_hold_state: assert property (
        (reg_mode && age_r > 4'h7 && !clk_or_in_pin) [*6]
        |-> $stable(cell_pin_out & ~mcfg_r[15:8]))
        else $error("registered output changed without clock");
    a_power_up_high: assert property (
        reg_mode && !seen_r && age_r > 4'h3 |-> (cell_pin_out | mcfg_r[15:8]) == 8'hFF)
        else $error("registered output low before first clock");
    a_comb_inputs_rule: assert property (
        (!reg_mode && age_r > 4'h7
        && $stable({ded_in, cell_pin_in, clk_or_in_pin, gate_n_or_in_pin})) [*4]
        |-> $stable(cell_pin_out) && $stable(cell_pin_oe))
        else $error("output moved with inputs still");
endmodule : sop_logic_array_properties

bind sop_logic_array sop_logic_array_properties #(.ADDR_W(ADDR_W)) i_sop_properties (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_or_in_pin(clk_or_in_pin), .gate_n_or_in_pin(gate_n_or_in_pin),
    .ded_in(ded_in), .cell_pin_in(cell_pin_in), .cell_pin_out(cell_pin_out),
    .cell_pin_oe(cell_pin_oe)
);

/* sop_logic_array_tb_top.sv */
`timescale 1ns/100ps
`define CHK(w, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", w, e, g); end end
module sop_logic_array_tb_top
    import sop_pkg::*;
();
    logic pclk = 1'b0;
    logic presetn, ce, psel, penable, pwrite, pready, pslverr, clk_pin, gate_n, re;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic [7:0] ded_in, cell_pin_in, cell_pin_out, cell_pin_oe, drv_val, drv_en;
    int mismatches = 0;
    int check_count = 0;

    always #2.5 pclk = ~pclk;

    sop_logic_array #(.ADDR_W(12)) i_sop_logic_array (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clk_or_in_pin(clk_pin), .gate_n_or_in_pin(gate_n),
        .ded_in(ded_in), .cell_pin_in(cell_pin_in), .cell_pin_out(cell_pin_out),
        .cell_pin_oe(cell_pin_oe));
    sop_board_model i_sop_board_model (.pclk(pclk), .drv_val(drv_val), .drv_en(drv_en),
        .cell_pin_out(cell_pin_out), .cell_pin_oe(cell_pin_oe), .cell_pin_in(cell_pin_in));

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Term 0 and 1 of a macrocell, the other six never true
    task automatic prog(input int k, input logic [31:0] w0, input logic [31:0] w1);
        for (int t = 0; t < 8; t++) begin
            apb(1'b1, 12'(32 * k + 4 * t), t == 0 ? w0 : (t == 1 ? w1 : 32'h0000_0003));
        end
    endtask : prog

    task automatic settle;
        repeat (5) @(posedge pclk);
    endtask : settle

    task automatic tick;
        clk_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        clk_pin <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : tick

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        stop_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, gate_n, paddr, pwdata} = '0;
        {ded_in, drv_val, drv_en} = '0;
        ce = 1'b1;
        clk_pin = 1'b0;
        repeat (10) @(posedge pclk);
        `CHK("reset pins", 16'h0000, {cell_pin_out, cell_pin_oe})
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, SOP_MODE_OFS, 32'h0);
        `CHK("mode reset", 32'h0, rq)
        apb(1'b1, SOP_MODE_OFS, 32'h3);
        apb(1'b0, SOP_MODE_OFS, 32'h0);
        `CHK("mode 3 ignored", 32'h0, rq)
        apb(1'b1, SOP_CELL_LAST, 32'hA5A5_5A5A);
        apb(1'b0, SOP_CELL_LAST, 32'h0);
        `CHK("last cell", 32'hA5A5_5A5A, rq)
        apb(1'b1, SOP_CELL_LAST, 32'h0);
        apb(1'b0, 12'h10C, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {re, rq})
        `CHK("simple oe", 8'hFF, cell_pin_oe)
        $display("test registers done");
        prog(0, 32'h0000_0005, 32'h0000_0003);
        prog(1, 32'h0000_0002, 32'h0000_0003);
        prog(4, 32'h0010_0000, 32'h0000_0003);
        apb(1'b1, SOP_MCFG_OFS, 32'h0011_000C);
        drv_en <= 8'h04;
        for (int i = 0; i < 8; i++) begin
            ded_in <= {i[2], 5'h00, i[1], i[0]};
            drv_val <= {5'h00, i[2], 2'h0};
            settle();
            `CHK("and terms", {i[0], i[0] & i[1]}, cell_pin_out[1:0])
            `CHK("pin feedback", i[2], cell_pin_out[4])
        end
        `CHK("input select", 8'hFB, cell_pin_oe)
        $display("test simple done");
        prog(0, 32'h0000_0001, 32'h0000_0004);
        prog(1, 32'h0000_0003, 32'h0000_0003);
        prog(2, 32'h0000_0000, 32'h0004_0000);
        prog(3, 32'h0000_0000, 32'h4000_0000);
        prog(5, 32'h0000_0000, 32'h0001_0000);
        apb(1'b1, SOP_MCFG_OFS, 32'h000D_0000);
        apb(1'b1, SOP_MODE_OFS, 32'h0000_0002);
        drv_en <= 8'h02;
        for (int i = 0; i < 8; i++) begin
            ded_in <= {6'h00, i[1], i[0]};
            drv_val <= {6'h00, i[2], 1'b0};
            gate_n <= i[1];
            clk_pin <= i[0];
            settle();
            `CHK("term enable", {2'h2, i[0]}, cell_pin_oe[2:0])
            `CHK("io feedback", {i[2], i[1]}, {cell_pin_out[2], cell_pin_out[0]})
            `CHK("pin 11 input", i[1], cell_pin_out[3])
            `CHK("pin 1 input", ~i[0], cell_pin_out[5])
        end
        $display("test medium done");
        gate_n <= 1'b0;
        clk_pin <= 1'b0;
        drv_en <= 8'h00;
        prog(0, 32'h0000_0001, 32'h0000_0003);
        prog(1, 32'h0008_0000, 32'h0000_0003);
        prog(2, 32'h0000_0000, 32'h0000_0003);
        apb(1'b1, SOP_MCFG_OFS, 32'h0001_0400);
        apb(1'b1, SOP_MODE_OFS, 32'h0000_0001);
        settle();
        `CHK("power-up high", 2'h3, cell_pin_out[1:0])
        gate_n <= 1'b1;
        settle();
        `CHK("gate high", 8'h04, cell_pin_oe)
        gate_n <= 1'b0;
        settle();
        `CHK("gate low", 8'hFF, cell_pin_oe)
        for (int j = 1; j < 5; j++) begin
            ded_in <= {7'h00, j[1]};
            tick();
            `CHK("captured", j[1], cell_pin_out[0])
            `CHK("toggle", ~j[0], cell_pin_out[1])
        end
        // A clock pulse while frozen is never seen; a read started frozen still answers
        ce <= 1'b0;
        tick();
        fork
            apb(1'b0, SOP_MODE_OFS, 32'h0);
            begin
                repeat (3) @(posedge pclk);
                ce <= 1'b1;
            end
        join
        `CHK("frozen read", 32'h1, rq)
        `CHK("frozen flops", 2'h2, cell_pin_out[1:0])
        $display("test registered done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, SOP_STAT_OFS, 32'h0);
        `CHK("flops cleared", 8'h00, rq[7:0])
        $display("test reset done");
        stop_test();
    end
endmodule : sop_logic_array_tb_top

/* sop_pkg.sv */
package sop_pkg;

    // ********************************************************
    // Array geometry
    // ********************************************************
    localparam int SOP_N_IN = 16;
    localparam int SOP_N_LINE = 32;
    localparam int SOP_N_TERM = 64;
    localparam int SOP_N_CELL = 8;
    localparam int SOP_TERMS_PER_CELL = 8;
    localparam int SOP_N_DED = 8;
    localparam int SOP_N_PIN_IN = 18;

    // ********************************************************
    // Register offsets (byte addresses)
    // ********************************************************
    localparam logic [11:0] SOP_CELL_BASE = 12'h000;
    localparam logic [11:0] SOP_CELL_LAST = 12'h0FC;
    localparam logic [11:0] SOP_MODE_OFS = 12'h100;
    localparam logic [11:0] SOP_MCFG_OFS = 12'h104;
    localparam logic [11:0] SOP_STAT_OFS = 12'h108;

    // ********************************************************
    // Field positions inside the macrocell configuration word
    // ********************************************************
    localparam int SOP_MCFG_IN_LSB = 0;
    localparam int SOP_MCFG_IO_LSB = 8;
    localparam int SOP_MCFG_POL_LSB = 16;

    // ********************************************************
    // Field positions inside the status word
    // ********************************************************
    localparam int SOP_STAT_Q_LSB = 0;
    localparam int SOP_STAT_OUT_LSB = 8;
    localparam int SOP_STAT_OE_LSB = 16;
    localparam int SOP_STAT_CLK_BIT = 24;
    localparam int SOP_STAT_GATE_BIT = 25;

    // ********************************************************
    // Values after reset
    // ********************************************************
    localparam logic [31:0] SOP_CELL_RST = 32'h0000_0000;
    localparam logic [7:0] SOP_IN_SEL_RST = 8'h00;
    localparam logic [7:0] SOP_IO_SEL_RST = 8'h00;
    localparam logic [7:0] SOP_POL_RST = 8'h00;
    localparam logic [7:0] SOP_Q_RST = 8'h00;

    // Macrocells whose feedback lines carry the two spare pins
    localparam int SOP_MID_LO = 3;
    localparam int SOP_MID_HI = 4;
    localparam int SOP_OUTER_LO = 0;
    localparam int SOP_OUTER_HI = 7;

    // ********************************************************
    // Architecture modes
    // ********************************************************
    typedef enum logic [1:0] {
        SOP_SIMPLE_COMBINATORIAL_MODE = 2'b00,
        SOP_REGISTERED_EMULATION_MODE = 2'b01,
        SOP_MEDIUM_COMBINATORIAL_MODE = 2'b10
    } sop_mode_t;

    localparam sop_mode_t SOP_MODE_RST = SOP_SIMPLE_COMBINATORIAL_MODE;

endpackage : sop_pkg
